// >>> rtl/two_line_serial_io.sv
// two-line clocked serial interface with avalon-mm register access
//
// Summary of operation
// - one clock line, one shared data line
// - mode byte writable; bits 7 and 5 bit-settable
// - mode register resets to zero
// - enable bit turns on shifting and pins
// - match flag follows address equals shift
// - match flag valid only outside transfers
// - mode byte write never changes match flag
// - wake-up zero sets done every transfer
// - msb first; upper bit picks data pin
// - clock select 00 takes external pin
// - clock select 01 uses timer output
// - selects 10/11 divide clock by 64
// - bus control bit-access only, resets zero
// - command trigger clears latch, self-clears
// - falling edge shifts msb out
// - rising edge captures selected data line
// - eight bits then stop and flag
// - start only if enabled and clock stopped or high
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/100ps
module two_line_serial_io (
  input  wire logic                       clk_i,               // system clock
  input  wire logic                       resetn_i,            // async reset, active low
  input  wire logic [sio_pkg::ADDR_W-1:0] avs_address_i,       // byte address
  input  wire logic                       avs_read_i,          // read request
  input  wire logic                       avs_write_i,         // write request
  input  wire logic [31:0]                avs_writedata_i,     // write data
  input  wire logic [3:0]                 avs_byteenable_i,    // byte lanes
  output logic [31:0]                     avs_readdata_o,      // read data
  output logic                            avs_waitrequest_o,   // stall
  input  wire logic                       sck_i,               // clock pin level
  output logic                            sck_o,               // clock pin drive
  output logic                            sck_oe_o,            // clock pin enable
  input  wire logic                       data_line_first_i,   // first data pin level
  output logic                            data_line_first_o,   // first data pin drive
  output logic                            data_line_first_oe_o,// first pin pulls low
  input  wire logic                       data_line_second_i,  // second data pin level
  output logic                            data_line_second_o,  // second data pin drive
  output logic                            data_line_second_oe_o,// second pin pulls low
  input  wire logic                       timer_output_i       // timer clock, same domain
);
  import sio_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // declarations
  logic        wait_q;      // waitrequest flop, high while idle
  logic [31:0] rdata_q;     // registered read data
  mode_s       mode_q;      // serial_operation_mode, match held zero
  logic [7:0]  busctl_q;    // serial_bus_control, triggers read zero
  logic [7:0]  sva_q;       // slave_address_register
  logic        cmd_fire_q;  // command trigger, one cycle
  logic        rel_fire_q;  // release trigger, one cycle
  logic        done_flag_q; // transfer_done_flag
  logic        match_q;     // address_match_flag
  logic [1:0]  sck_sync_q;  // clock pin synchroniser
  logic [1:0]  d1_sync_q;   // first data pin synchroniser
  logic [1:0]  d2_sync_q;   // second data pin synchroniser
  logic        sck_out_q;   // clock pin drive flop
  logic        sck_oe_q;    // clock pin enable flop
  logic        d1_oe_q;     // first pin pull-low flop
  logic        d2_oe_q;     // second pin pull-low flop
  logic        wr_acc;      // write taken this edge
  logic        be0;         // low byte lane enabled
  logic        start_ok;    // transfer may start
  logic        din;         // selected data line
  logic [7:0]  shreg_w;     // shift register
  logic        so_w;        // output latch
  logic        busy_w;      // transfer running
  logic        done_w;      // end of transfer pulse
  sclk_s       sclk_w;      // serial clock and edges

  assign wr_acc = avs_write_i && !wait_q;
  assign be0    = avs_byteenable_i[0];

  //////////////////////////////////////////////////////////////////////
  // avalon handshake: one wait cycle, then answer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wait_q <= 1'b1;
    end else if ((avs_read_i || avs_write_i) && wait_q) begin
      wait_q <= 1'b0; // answer next cycle
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read data decode, zero for unmapped
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && wait_q) begin
      if (avs_address_i == OFF_MODE) begin
        rdata_q <= {24'h00_0000, mode_q.enable, match_q, mode_q[5:0]};
      end else if (avs_address_i == OFF_SHIFT) begin
        rdata_q <= {24'h00_0000, shreg_w};
      end else if (avs_address_i == OFF_SLAVE_ADDR) begin
        rdata_q <= {24'h00_0000, sva_q};
      end else if (avs_address_i == OFF_STATUS) begin
        rdata_q <= {30'h0000_0000, busy_w, done_flag_q};
      end else begin
        rdata_q <= 32'h0000_0000; // write-only or unmapped
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // mode register: byte write and single-bit operations
  // cleared at reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_q <= mode_s'(MODE_RESET);
    end else if (wr_acc && be0 && avs_address_i == OFF_MODE) begin
      mode_q       <= mode_s'(avs_writedata_i[7:0]);
      mode_q.match <= 1'b0;
    end else if (wr_acc && be0 && avs_address_i == OFF_MODE_BITOP) begin
      // set or clear bits 7 and 5
      if (avs_writedata_i[2:0] == 3'(MODE_EN_BIT)) begin
        mode_q.enable <= avs_writedata_i[BITOP_VAL_BIT];
      end else if (avs_writedata_i[2:0] == 3'(MODE_WAKE_BIT)) begin
        mode_q.wake <= avs_writedata_i[BITOP_VAL_BIT];
      end
    end
  end

  // bus control: single-bit access only, triggers self-clear
  // bit operations, zero at reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      busctl_q   <= BUSCTL_RESET;
      cmd_fire_q <= 1'b0;
      rel_fire_q <= 1'b0;
    end else begin
      cmd_fire_q <= 1'b0;
      rel_fire_q <= 1'b0;
      if (wr_acc && be0 && avs_address_i == OFF_BUS_BITOP) begin
        if (avs_writedata_i[2:0] == 3'(BUS_CMD_BIT)) begin
          cmd_fire_q <= avs_writedata_i[BITOP_VAL_BIT];
        end else if (avs_writedata_i[2:0] == 3'(BUS_REL_BIT)) begin
          rel_fire_q <= avs_writedata_i[BITOP_VAL_BIT];
        end else begin
          busctl_q[avs_writedata_i[2:0]] <= avs_writedata_i[BITOP_VAL_BIT];
        end
      end
    end
  end

  // slave address register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sva_q <= SLAVE_RESET;
    end else if (wr_acc && be0 && avs_address_i == OFF_SLAVE_ADDR) begin
      sva_q <= avs_writedata_i[7:0];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // status: done flag, set wins over clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      done_flag_q <= 1'b0;
    end else if (done_w && mode_q.enable && !mode_q.wake) begin
      done_flag_q <= 1'b1;
    end else if (done_w && mode_q.enable && (sva_q == shreg_w)) begin
      done_flag_q <= 1'b1; // wake-up: only on match of the final word
    end else if (wr_acc && be0 && avs_address_i == OFF_STATUS &&
                 avs_writedata_i[STAT_DONE_BIT]) begin
      done_flag_q <= 1'b0;
    end
  end

  // address comparator, meaningful only when idle
  // compare slave address with shift register
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      match_q <= 1'b1; // address and shift register both reset to zero
    end else begin
      match_q <= (sva_q == shreg_w);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops before any use
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_sync_q <= 2'b11;
      d1_sync_q  <= 2'b11;
      d2_sync_q  <= 2'b11;
    end else begin
      sck_sync_q <= {sck_sync_q[0], sck_i};
      d1_sync_q  <= {d1_sync_q[0], data_line_first_i};
      d2_sync_q  <= {d2_sync_q[0], data_line_second_i};
    end
  end

  // one data line chosen by upper bit
  assign din = mode_q.sel_upper ? d2_sync_q[1] : d1_sync_q[1];

  // start when enabled and clock stopped or high
  assign start_ok = mode_q.enable && (!busy_w || sclk_w.level);

  //////////////////////////////////////////////////////////////////////
  // serial clock source
  serial_clock_gen u_clk (
    .clk_i     (clk_i),
    .resetn_i  (resetn_i),
    .run_i     (busy_w),
    .clk_sel_i (mode_q.clk_sel),
    .timer_i   (timer_output_i),
    .ext_i     (sck_sync_q[1]),
    .sclk_o    (sclk_w)
  );

  // shift register and output latch
  serial_shift_engine u_shift (
    .clk_i    (clk_i),
    .resetn_i (resetn_i),
    .load_i   (wr_acc && be0 && avs_address_i == OFF_SHIFT),
    .start_i  (start_ok),
    .data_i   (avs_writedata_i[7:0]),
    .sclk_i   (sclk_w),
    .din_i    (din),
    .so_clr_i (cmd_fire_q),
    .so_set_i (rel_fire_q),
    .shreg_o  (shreg_w),
    .so_o     (so_w),
    .busy_o   (busy_w),
    .done_o   (done_w)
  );

  //////////////////////////////////////////////////////////////////////
  // pin drive flops
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sck_out_q <= 1'b1;
      sck_oe_q  <= 1'b0;
      d1_oe_q   <= 1'b0;
      d2_oe_q   <= 1'b0;
    end else begin
      sck_out_q <= sclk_w.level;
      // pin is input for external clock
      sck_oe_q  <= mode_q.enable && (mode_q.clk_sel != CLK_EXT);
      // pull low only for a zero latch
      d1_oe_q   <= mode_q.enable && !mode_q.sel_upper && !so_w;
      d2_oe_q   <= mode_q.enable && mode_q.sel_upper && !so_w;
    end
  end

  assign avs_readdata_o        = rdata_q;
  assign avs_waitrequest_o     = wait_q;
  assign sck_o                 = sck_out_q;
  assign sck_oe_o              = sck_oe_q;
  assign data_line_first_o     = 1'b0; // open drain, low only
  assign data_line_first_oe_o  = d1_oe_q;
  assign data_line_second_o    = 1'b0; // open drain, low only
  assign data_line_second_oe_o = d2_oe_q;

  //////////////////////////////////////////////////////////////////////
  // assertions
  a_cmd_clears_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cmd_fire_q && !busy_w |=> !so_w)
    else $error("command trigger did not clear output latch");

  a_rel_sets_latch: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rel_fire_q && !cmd_fire_q && !busy_w |=> so_w)
    else $error("release trigger did not set output latch");

  a_trigger_selfclear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    cmd_fire_q |=> !cmd_fire_q)
    else $error("command trigger did not return to zero");

  a_match_when_idle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !busy_w ##1 !busy_w |-> match_q == ($past(sva_q) == $past(shreg_w)))
    else $error("address match flag wrong while idle");

  a_done_sets_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done_w && mode_q.enable && !mode_q.wake |=> done_flag_q)
    else $error("transfer done flag not set");

  a_no_start_disabled: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !busy_w && !mode_q.enable && wr_acc && avs_address_i == OFF_SHIFT |=> !busy_w)
    else $error("transfer started while disabled");

  a_pin_pull_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    data_line_first_oe_o |-> !$past(so_w) && $past(mode_q.enable) && !$past(mode_q.sel_upper))
    else $error("first data pin pulled low without zero latch");

  a_wait_one_cycle: assert property (@(posedge clk_i) disable iff (!resetn_i)
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("waitrequest answer not one cycle");

  a_mode_byte_write: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_acc && be0 && avs_address_i == OFF_MODE |=> !mode_q.match &&
    mode_q.enable == $past(avs_writedata_i[MODE_EN_BIT]))
    else $error("mode byte write stored wrongly");

  a_eight_bits_end: assert property (@(posedge clk_i) disable iff (!resetn_i)
    done_w |-> !busy_w)
    else $error("shifter still busy after eight bits");
endmodule

// >>> common/sio_pkg.sv
// package: constants, offsets and carrier types of the two-line serial block
package sio_pkg;
  // system clock rate
  localparam int unsigned SYS_CLK_HZ     = 100_000_000;
  // internal serial clock is the system clock divided by 64
  localparam int unsigned SCK_DIV        = 64;
  // system clock cycles per serial clock half period
  localparam int unsigned SCK_HALF       = SCK_DIV / 2;
  // word length of one transfer
  localparam int unsigned SHIFT_BITS     = 8;

  // avalon byte offsets, one aligned word each
  localparam int unsigned ADDR_W         = 5;
  localparam logic [4:0]  OFF_MODE       = 5'h00;
  localparam logic [4:0]  OFF_MODE_BITOP = 5'h04;
  localparam logic [4:0]  OFF_BUS_BITOP  = 5'h08;
  localparam logic [4:0]  OFF_SHIFT      = 5'h0c;
  localparam logic [4:0]  OFF_SLAVE_ADDR = 5'h10;
  localparam logic [4:0]  OFF_STATUS     = 5'h14;

  // values after reset
  localparam logic [7:0]  MODE_RESET     = 8'h00;
  localparam logic [7:0]  BUSCTL_RESET   = 8'h00;
  localparam logic [7:0]  SLAVE_RESET    = 8'h00;

  // bit positions in the mode register
  localparam int unsigned MODE_EN_BIT    = 7;
  localparam int unsigned MODE_MATCH_BIT = 6;
  localparam int unsigned MODE_WAKE_BIT  = 5;
  // bit positions in the bus control register
  localparam int unsigned BUS_CMD_BIT    = 7;
  localparam int unsigned BUS_REL_BIT    = 6;
  // single-bit operation word: value bit and bit index field
  localparam int unsigned BITOP_VAL_BIT  = 3;
  // status word bits
  localparam int unsigned STAT_DONE_BIT  = 0;
  localparam int unsigned STAT_BUSY_BIT  = 1;

  // clock select encodings
  localparam logic [1:0]  CLK_EXT        = 2'b00;
  localparam logic [1:0]  CLK_TIMER      = 2'b01;

  // mode register fields
  typedef struct packed {
    logic       enable;    // interface_enable_bit
    logic       match;     // address_match_flag, read only
    logic       wake;      // wake_up_select
    logic       sel_upper; // mode_select_upper
    logic       sel_mid;   // mode_select_middle
    logic       sel_low;   // mode_select_lower
    logic [1:0] clk_sel;   // clock_select_high/low
  } mode_s;

  // serial clock level with its edge pulses
  typedef struct packed {
    logic level; // current serial clock level
    logic fall;  // one-cycle falling edge
    logic rise;  // one-cycle rising edge
  } sclk_s;

  // shifter state
  typedef enum logic [0:0] {
    SH_IDLE = 1'b0,
    SH_RUN  = 1'b1
  } shift_state_e;
endpackage

// >>> rtl/serial_clock_gen.sv
// serial clock source selection, divider and edge detection
`timescale 1ns/100ps
module serial_clock_gen (
  input  wire logic          clk_i,      // system clock
  input  wire logic          resetn_i,   // async reset, active low
  input  wire logic          run_i,      // transfer in progress
  input  wire logic [1:0]    clk_sel_i,  // clock select field
  input  wire logic          timer_i,    // timer_output level, same domain
  input  wire logic          ext_i,      // synchronised external clock
  output sio_pkg::sclk_s     sclk_o      // level and edge pulses
);
  import sio_pkg::*;

  logic [5:0] div_q;   // half-period counter
  logic       int_q;   // internal divided clock, idles high
  logic       lvl_d;   // selected level
  logic       prev_q;  // level one cycle ago

  //////////////////////////////////////////////////////////////////////
  // internal divider, stopped high outside a transfer
  // divide by 64
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      div_q <= 6'h00;
      int_q <= 1'b1;
    end else if (!run_i || !clk_sel_i[1]) begin
      div_q <= 6'h00; // masked clock
      int_q <= 1'b1;
    end else if (div_q == 6'(SCK_HALF - 1)) begin
      div_q <= 6'h00; // half period done
      int_q <= ~int_q;
    end else begin
      div_q <= div_q + 6'h01;
    end
  end

  // source select
  // external pin, timer output or internal divided clock
  always_comb begin
    if (clk_sel_i == CLK_EXT) begin
      lvl_d = ext_i;
    end else if (clk_sel_i == CLK_TIMER) begin
      lvl_d = run_i ? timer_i : 1'b1; // masked at end
    end else begin
      lvl_d = int_q;
    end
  end

  // previous level for edge detection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_q <= 1'b1;
    end else begin
      prev_q <= lvl_d;
    end
  end

  // level, falling pulse, rising pulse in one driver
  assign sclk_o = {lvl_d, prev_q & ~lvl_d, ~prev_q & lvl_d};
endmodule

// >>> rtl/serial_shift_engine.sv
// eight-bit shift register, output latch and bit counter
`timescale 1ns/100ps
module serial_shift_engine (
  input  wire logic          clk_i,      // system clock
  input  wire logic          resetn_i,   // async reset, active low
  input  wire logic          load_i,     // write to shift register
  input  wire logic          start_i,    // start with this load
  input  wire logic [7:0]    data_i,     // word to load
  input  sio_pkg::sclk_s     sclk_i,     // serial clock edges
  input  wire logic          din_i,      // selected data line level
  input  wire logic          so_clr_i,   // command trigger pulse
  input  wire logic          so_set_i,   // release trigger pulse
  output logic [7:0]         shreg_o,    // shift register contents
  output logic               so_o,       // output latch
  output logic               busy_o,     // transfer running
  output logic               done_o      // one-cycle end of transfer
);
  import sio_pkg::*;

  shift_state_e state_q; // idle or running
  logic [2:0]   cnt_q;   // bits captured so far
  logic [7:0]   sh_q;    // shift register
  logic         so_q;    // output latch
  logic         done_q;  // end pulse

  //////////////////////////////////////////////////////////////////////
  // sequencer: start, count eight bits, stop
  // stop after eight bits
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q <= SH_IDLE;
      cnt_q   <= 3'h0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (state_q)
        SH_IDLE: begin
          if (load_i && start_i) begin
            state_q <= SH_RUN;
            cnt_q   <= 3'h0;
          end
        end
        SH_RUN: begin
          if (load_i && start_i) begin
            cnt_q <= 3'h0; // restart with new word
          end else if (sclk_i.rise) begin
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'(SHIFT_BITS - 1)) begin
              state_q <= SH_IDLE;
              done_q  <= 1'b1;
            end
          end
        end
        default: state_q <= SH_IDLE;
      endcase
    end
  end

  // shift register: load, then capture on rising edges
  // capture on rising edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sh_q <= 8'h00;
    end else if (load_i) begin
      sh_q <= data_i;
    end else if (state_q == SH_RUN && sclk_i.rise) begin
      sh_q <= {sh_q[6:0], din_i};
    end
  end

  // output latch: msb first, updated on falling edges
  // drive msb on falling edge
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      so_q <= 1'b1;
    end else if (load_i && start_i) begin
      so_q <= data_i[7];
    end else if (state_q == SH_RUN && sclk_i.fall) begin
      so_q <= sh_q[7];
    end else if (so_clr_i) begin
      so_q <= 1'b0;
    end else if (so_set_i) begin
      so_q <= 1'b1;
    end
  end

  assign shreg_o = sh_q;
  assign so_o    = so_q;
  assign busy_o  = (state_q == SH_RUN);
  assign done_o  = done_q;
endmodule

// >>> verif/serial_peer_model.sv
// far-side peer: clock source and open-drain talker on the shared line
`timescale 1ns/100ps
module serial_peer_model (
  input  wire logic       clk_i,    // system clock
  input  wire logic       resetn_i, // async reset, active low
  input  wire logic       go_i,     // start one word
  input  wire logic       gen_i,    // peer makes the clock
  input  wire logic [7:0] tx_i,     // word to send
  input  wire logic       sck_i,    // clock line level
  input  wire logic       d_i,      // data line level
  output logic            sck_o,    // clock drive, idles high
  output logic            pull_o,   // pulls data line low
  output logic [7:0]      sh_o      // shift contents
);
  logic [7:0] c_q;   // clock phase count
  logic       prv_q; // last clock level
  logic       lat_q; // output latch
  logic       act_q; // word in flight
  logic [3:0] n_q;   // rising edges seen
  assign sck_o = !c_q[3];
  // line pulled low only for a zero
  assign pull_o = act_q & !lat_q;
  // latch on fall, capture on rise
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      c_q <= 8'h00;
      prv_q <= 1'b1;
      lat_q <= 1'b1;
      act_q <= 1'b0;
      n_q <= 4'h0;
      sh_o <= 8'h00;
    end else begin
      prv_q <= sck_i;
      if (go_i && gen_i) c_q <= 8'h01;
      else if (c_q != 8'h00) c_q <= (c_q == 8'h87) ? 8'h00 : c_q + 8'h01;
      if (go_i) begin
        sh_o <= tx_i;
        lat_q <= tx_i[7];
        act_q <= 1'b1;
        n_q <= 4'h0;
      end else if (act_q && prv_q && !sck_i) lat_q <= sh_o[7];
      else if (act_q && !prv_q && sck_i) begin
        sh_o <= {sh_o[6:0], d_i};
        n_q <= n_q + 4'h1;
        act_q <= (n_q != 4'h7);
      end
    end
  end
endmodule

// >>> verif/two_line_serial_io_tb_top.sv
// bench: register accesses and word transfers against a serial peer
`timescale 1ns/100ps
module two_line_serial_io_tb_top;
  import sio_pkg::*;
  logic clk, rstn, rd, wr, go, gen, sel2, tmr, wq, sck, sck_oe, f_oe, s_oe, p_sck, pull;
  logic [4:0]  adr;
  logic [31:0] wd, rdat;
  logic [7:0]  q, ptx, prx;
  int          miscompares, n_compared, cyc;
  realtime     t;
  // wired clock and open-drain data lines with pull-up
  wire sck_w = sck_oe ? sck : p_sck;
  wire l1 = !(f_oe | (pull & !sel2));
  wire l2 = !(s_oe | (pull & sel2));
  two_line_serial_io i_dut (.clk_i(clk), .resetn_i(rstn), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .sck_i(sck_w), .sck_o(sck), .sck_oe_o(sck_oe), .data_line_first_i(l1),
    .data_line_first_o(), .data_line_first_oe_o(f_oe), .data_line_second_i(l2), .data_line_second_o(),
    .data_line_second_oe_o(s_oe), .timer_output_i(tmr));
  serial_peer_model i_peer (.clk_i(clk), .resetn_i(rstn), .go_i(go), .gen_i(gen), .tx_i(ptx),
    .sck_i(sck_w), .d_i(sel2 ? l2 : l1), .sck_o(p_sck), .pull_o(pull), .sh_o(prx));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // timer toggle and hang limit
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tmr <= cyc[2];
    if (cyc > 20000) begin
      miscompares++;
      end_sim;
    end
  end
  task end_sim;
    if (miscompares == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      miscompares++;
    end
  endtask
  // one avalon access, held until waitrequest low
  task acc(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    adr <= a; rd <= !w; wr <= w; wd <= {24'h0, d};
    do @(posedge clk); while (wq !== 1'b0);
    q = rdat[7:0];
    rd <= 0; wr <= 0;
  endtask
  // load word, start peer, check clock period, wait for done flag
  task xfer(input logic [7:0] d, input logic [7:0] p, input logic [7:0] per);
    acc(1, OFF_STATUS, 8'h01);
    acc(1, OFF_SHIFT, d);
    ptx <= p; go <= 1;
    @(posedge clk) go <= 0;
    if (per != 0) begin
      @(negedge sck_w);
      @(negedge sck_w) t = $realtime;
      @(negedge sck_w) chk("period", per, 8'(int'(($realtime - t) / 10)));
    end
    do acc(0, OFF_STATUS, 0); while (q[0] !== 1'b1);
    chk("peer rx", d & p, prx);
    acc(0, OFF_SHIFT, 0);
    chk("dev rx", d & p, q);
  endtask
  initial begin
    rstn = 0; rd = 0; wr = 0; go = 0; gen = 0; sel2 = 0; adr = 0; wd = 0; ptx = 0;
    repeat (6) @(posedge clk);
    rstn <= 1;
    acc(0, OFF_MODE, 0);
    chk("mode reset", 8'h00, q & 8'hbf);
    acc(0, 5'h18, 0);
    chk("unmapped", 8'h00, q);
    gen <= 1;
    acc(1, OFF_MODE, 8'h8c);
    xfer(8'ha5, 8'h3c, 0);
    acc(1, OFF_SLAVE_ADDR, 8'h24);
    acc(1, OFF_MODE, 8'h8c);
    acc(0, OFF_MODE, 0);
    chk("match", 8'hcc, q);
    acc(1, OFF_SLAVE_ADDR, 8'h25);
    acc(1, OFF_MODE, 8'hcc);
    acc(0, OFF_MODE, 0);
    chk("no match", 8'h8c, q);
    gen <= 0; sel2 <= 1;
    acc(1, OFF_MODE, 8'h9e);
    xfer(8'hff, 8'h81, 64);
    acc(1, OFF_MODE, 8'h9d);
    xfer(8'hff, 8'h5a, 8);
    acc(1, OFF_MODE, 8'h9f);
    xfer(8'h3c, 8'hff, 64);
    acc(1, OFF_BUS_BITOP, 8'h0e);
    repeat (3) @(posedge clk);
    chk("rel pull", 8'h00, {7'h0, s_oe});
    acc(1, OFF_BUS_BITOP, 8'h0f);
    repeat (3) @(posedge clk);
    chk("cmd pull", 8'h01, {7'h0, s_oe});
    acc(1, OFF_MODE_BITOP, 8'h07);
    acc(1, OFF_MODE_BITOP, 8'h0d);
    acc(0, OFF_MODE, 0);
    chk("bit ops", 8'h3f, q & 8'hbf);
    chk("disabled pin", 8'h00, {7'h0, s_oe});
    acc(1, OFF_SHIFT, 8'h00);
    repeat (40) @(posedge clk);
    acc(0, OFF_STATUS, 0);
    chk("no start", 8'h00, q & 8'h02);
    end_sim;
  end
endmodule
